// *** rtl/slp_pkg.sv ***
// Shared constants for the sensor serial register port
`default_nettype none
package slp_pkg;
	// ---------------------------------------------------------------
	// Clock and link timing
	// ---------------------------------------------------------------
	localparam int CLK_NS     = 40;
	localparam int SPI_MIN_NS = 500;
	localparam int I2C_TLO_NS = 660;
	localparam int I2C_THI_NS = 330;
	// Least half period of the serial clock, rounded up
	localparam int SPI_HALF   = (SPI_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;
	// Quarter bit: two quarters must cover the low time
	localparam int I2C_QTR    = (I2C_TLO_NS / 2 + CLK_NS - 1) / CLK_NS;

	// ---------------------------------------------------------------
	// Command layout and direct commands
	// ---------------------------------------------------------------
	localparam int          ADDR_W         = 6;
	localparam logic [1:0]  MODE_WRITE     = 2'h0;
	localparam logic [1:0]  MODE_READ      = 2'h1;
	localparam logic [3:0]  SPI_CMD_LAST   = 4'h7;
	localparam logic [3:0]  SPI_DATA_LAST  = 4'hF;
	localparam logic [3:0]  SPI_DATA_FIRST = 4'h8;
	localparam logic [4:0]  SPI_BITS       = 5'h10;
	localparam logic [3:0]  I2C_BITS       = 4'h8;
	localparam logic [3:0]  I2C_DEV_PREFIX = 4'h0;
	localparam logic [7:0]  DC_MAGIC       = 8'h96;
	localparam logic [5:0]  ADDR_RESTORE   = 6'h3C;
	localparam logic [5:0]  ADDR_CALIB     = 6'h3D;
	localparam logic [1:0]  KIND_DEV       = 2'h0;
	localparam logic [1:0]  KIND_WA        = 2'h1;
	localparam logic [1:0]  KIND_DATA      = 2'h2;

	// ---------------------------------------------------------------
	// Controller registers
	// ---------------------------------------------------------------
	localparam logic [7:0]  HR_ADDR        = 8'h00;
	localparam logic [7:0]  HR_WDATA       = 8'h04;
	localparam logic [7:0]  HR_CTRL        = 8'h08;
	localparam logic [7:0]  HR_STATUS      = 8'h0C;
	localparam logic [7:0]  HR_RDATA       = 8'h10;
	localparam int          CTRL_WR        = 0;
	localparam int          CTRL_RD        = 1;
	localparam int          CTRL_I2C       = 2;
	localparam int          CTRL_ASEL_LO   = 3;
	localparam int          CTRL_ASEL_HI   = 4;

	// ---------------------------------------------------------------
	// I2C frame slots, symbol kinds and roles
	// ---------------------------------------------------------------
	localparam logic [5:0]  SL_DEV         = 6'h01;
	localparam logic [5:0]  SL_ACK1        = 6'h09;
	localparam logic [5:0]  SL_WA          = 6'h0A;
	localparam logic [5:0]  SL_ACK2        = 6'h12;
	localparam logic [5:0]  SL_WDAT        = 6'h13;
	localparam logic [5:0]  SL_WACK        = 6'h1B;
	localparam logic [5:0]  SL_RSTART      = 6'h13;
	localparam logic [5:0]  SL_DEVR        = 6'h14;
	localparam logic [5:0]  SL_RACK        = 6'h1C;
	localparam logic [5:0]  SL_RDAT        = 6'h1D;
	localparam logic [5:0]  SL_NACK        = 6'h25;
	localparam logic [5:0]  SL_SPAN        = 6'h07;
	localparam logic [1:0]  K_BIT          = 2'h0;
	localparam logic [1:0]  K_START        = 2'h1;
	localparam logic [1:0]  K_STOP         = 2'h2;
	localparam logic [1:0]  R_DRV          = 2'h0;
	localparam logic [1:0]  R_RX           = 2'h1;
	localparam logic [1:0]  R_ACK          = 2'h2;
	localparam logic [1:0]  R_NACK         = 2'h3;
endpackage
`default_nettype wire

// *** rtl/slp_if.sv ***
// Pin bundle joining the sensor port and its bus master
`timescale 1ns/1ps
`default_nettype none
interface slp_if;
	logic spi_cs_n, spi_sclk, spi_mosi, spi_miso_o, spi_miso_oe_n, spi_miso;
	logic host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n;
	logic dev_sda_o, dev_sda_oe_n, scl, sda;

	// Released return line reads high; I2C lines are wired-AND with pull-ups
	assign spi_miso = spi_miso_oe_n ? 1'b1 : spi_miso_o;
	assign scl      = host_scl_oe_n ? 1'b1 : host_scl_o;
	assign sda      = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport device (
		input  spi_cs_n, spi_sclk, spi_mosi, scl, sda,
		output spi_miso_o, spi_miso_oe_n, dev_sda_o, dev_sda_oe_n
	);
	modport host (
		input  spi_miso, scl, sda,
		output spi_cs_n, spi_sclk, spi_mosi, host_scl_o, host_scl_oe_n,
		output host_sda_o, host_sda_oe_n
	);
endinterface
`default_nettype wire

// *** rtl/slp_device.sv ***
// Sensor side of the serial register port: SPI and I2C slave
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module slp_device (
	// Clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_reset,
	// Strap pins
	input  wire logic                       i_interface_select,
	input  wire logic                       i_addr_sel_high,
	input  wire logic                       i_addr_sel_low,
	// Register side
	output logic                            o_reg_wr,
	output logic                            o_reg_rd,
	output logic [slp_pkg::ADDR_W-1:0]      o_reg_addr,
	output logic [7:0]                      o_reg_wdata,
	input  wire logic [7:0]                 i_reg_rdata,
	output logic                            o_restore_defaults,
	output logic                            o_calibrate,
	// Serial pins
	slp_if.device                           bus
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic cs_n, sclk, mosi, scl, sda, isel, asel_hi, asel_lo;
	} slp_pins_t;
	typedef enum logic [3:0] {
		SP_CMD = 4'h1, SP_WR = 4'h2, SP_RD = 4'h4, SP_IGN = 4'h8
	} slp_spi_t;
	typedef enum logic [4:0] {
		I_IDLE = 5'h01, I_RECV = 5'h02, I_ACK = 5'h04, I_SEND = 5'h08, I_MACK = 5'h10
	} slp_i2c_t;
	typedef struct packed {
		slp_pins_t                  s1, s2, s3;
		slp_spi_t                   sst;
		logic [3:0]                 scnt;
		logic [7:0]                 ssh;
		logic [slp_pkg::ADDR_W-1:0] saddr;
		slp_i2c_t                   ist;
		logic [3:0]                 icnt;
		logic [7:0]                 ish;
		logic [1:0]                 ikind;
		logic [slp_pkg::ADDR_W-1:0] iwa;
		logic                       irdm;
		logic [7:0]                 tx;
		logic                       ld, miso, miso_oe_n, sda_oe_n;
		logic                       reg_wr, reg_rd, restore, calib;
		logic [slp_pkg::ADDR_W-1:0] reg_addr;
		logic [7:0]                 reg_wdata;
	} slp_dev_st_t;

	slp_dev_st_t st_ff, nxt_st;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic                       wr_req;
		logic [slp_pkg::ADDR_W-1:0] wr_addr;
		logic [7:0]                 wr_data;
		logic                       s_fall, s_rise, i_fall, i_rise, i_start, i_stop;
		wr_req  = 1'b0;
		wr_addr = '0;
		wr_data = '0;
		s_fall  = st_ff.s3.sclk & ~st_ff.s2.sclk;
		s_rise  = ~st_ff.s3.sclk & st_ff.s2.sclk;
		i_fall  = st_ff.s3.scl & ~st_ff.s2.scl;
		i_rise  = ~st_ff.s3.scl & st_ff.s2.scl;
		i_start = st_ff.s3.sda & ~st_ff.s2.sda & st_ff.s2.scl & st_ff.s3.scl;
		i_stop  = ~st_ff.s3.sda & st_ff.s2.sda & st_ff.s2.scl & st_ff.s3.scl;
		nxt_st  = st_ff;
		// Two-stage synchronisers, third stage only for edge finding
		nxt_st.s1 = {bus.spi_cs_n, bus.spi_sclk, bus.spi_mosi, bus.scl, bus.sda,
			i_interface_select, i_addr_sel_high, i_addr_sel_low};
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.reg_wr  = 1'b0;
		nxt_st.reg_rd  = 1'b0;
		nxt_st.restore = 1'b0;
		nxt_st.calib   = 1'b0;
		// Read data arrives the cycle after the read strobe
		nxt_st.ld = st_ff.reg_rd;
		if (st_ff.ld) begin
			nxt_st.tx = i_reg_rdata;
		end

		// SPI slave
		// SPI only with select low
		if (st_ff.s2.cs_n || st_ff.s2.isel) begin
			nxt_st.sst       = SP_CMD;
			nxt_st.scnt      = '0;
			nxt_st.miso_oe_n = 1'b1;
		end else begin
			nxt_st.miso_oe_n = 1'b0;
			if (s_fall) begin
				nxt_st.ssh  = {st_ff.ssh[6:0], st_ff.s2.mosi};
				nxt_st.scnt = st_ff.scnt + 4'h1;
				if (st_ff.scnt == slp_pkg::SPI_CMD_LAST) begin
					nxt_st.saddr = nxt_st.ssh[slp_pkg::ADDR_W-1:0];
					if (nxt_st.ssh[7:6] == slp_pkg::MODE_READ) begin
						nxt_st.sst      = SP_RD;
						nxt_st.reg_rd   = 1'b1;
						nxt_st.reg_addr = nxt_st.ssh[slp_pkg::ADDR_W-1:0];
					end else if (nxt_st.ssh[7:6] == slp_pkg::MODE_WRITE) begin
						nxt_st.sst = SP_WR;
					end else begin
						nxt_st.sst = SP_IGN;
					end
				end else if (st_ff.scnt == slp_pkg::SPI_DATA_LAST) begin
					// Wrap back to data phase for bursts
					nxt_st.scnt  = slp_pkg::SPI_DATA_FIRST;
					nxt_st.saddr = st_ff.saddr + 1'b1;
					if (st_ff.sst == SP_WR) begin
						wr_req  = 1'b1;
						wr_addr = st_ff.saddr;
						wr_data = nxt_st.ssh;
					end
					if (st_ff.sst == SP_RD) begin
						nxt_st.reg_rd   = 1'b1;
						nxt_st.reg_addr = st_ff.saddr + 1'b1;
					end
				end
			end
			if (s_rise && st_ff.sst == SP_RD) begin
				nxt_st.miso = st_ff.tx[7];
				nxt_st.tx   = {st_ff.tx[6:0], 1'b0};
			end
		end

		// I2C slave
		// I2C only with select high
		if (!st_ff.s2.isel) begin
			nxt_st.ist      = I_IDLE;
			nxt_st.sda_oe_n = 1'b1;
		end else if (i_start) begin
			nxt_st.ist      = I_RECV;
			nxt_st.icnt     = '0;
			nxt_st.ikind    = slp_pkg::KIND_DEV;
			nxt_st.irdm     = 1'b0;
			nxt_st.sda_oe_n = 1'b1;
		end else if (i_stop) begin
			nxt_st.ist      = I_IDLE;
			nxt_st.sda_oe_n = 1'b1;
		end else begin
			unique case (st_ff.ist)
				I_IDLE: begin
				end
				I_RECV: begin
					if (i_rise) begin
						nxt_st.ish  = {st_ff.ish[6:0], st_ff.s2.sda};
						nxt_st.icnt = st_ff.icnt + 4'h1;
					end
					if (i_fall && st_ff.icnt == slp_pkg::I2C_BITS) begin
						nxt_st.icnt     = '0;
						nxt_st.ist      = I_ACK;
						nxt_st.sda_oe_n = 1'b0;
						if (st_ff.ikind == slp_pkg::KIND_DEV) begin
							// match own address
							// Leading zero pads the six address bits to seven
							if (st_ff.ish[7:1] == {1'b0, slp_pkg::I2C_DEV_PREFIX,
								st_ff.s2.asel_hi, st_ff.s2.asel_lo}) begin
								nxt_st.irdm  = st_ff.ish[0];
								nxt_st.ikind = slp_pkg::KIND_WA;
								// fetch byte at stored word address
								nxt_st.reg_rd   = st_ff.ish[0];
								nxt_st.reg_addr = st_ff.iwa;
							end else begin
								nxt_st.ist      = I_IDLE;
								nxt_st.sda_oe_n = 1'b1;
							end
						end else if (st_ff.ikind == slp_pkg::KIND_WA) begin
							nxt_st.iwa   = st_ff.ish[slp_pkg::ADDR_W-1:0];
							nxt_st.ikind = slp_pkg::KIND_DATA;
						end else begin
							wr_req     = 1'b1;
							wr_addr    = st_ff.iwa;
							wr_data    = st_ff.ish;
							nxt_st.iwa = st_ff.iwa + 1'b1;
						end
					end
				end
				I_ACK: begin
					if (i_fall && st_ff.irdm) begin
						nxt_st.ist      = I_SEND;
						nxt_st.sda_oe_n = st_ff.tx[7];
						nxt_st.tx       = {st_ff.tx[6:0], 1'b0};
						nxt_st.icnt     = 4'h1;
					end else if (i_fall) begin
						nxt_st.ist      = I_RECV;
						nxt_st.sda_oe_n = 1'b1;
					end
				end
				I_SEND: begin
					if (i_fall && st_ff.icnt == slp_pkg::I2C_BITS) begin
						nxt_st.ist      = I_MACK;
						nxt_st.sda_oe_n = 1'b1;
					end else if (i_fall) begin
						nxt_st.sda_oe_n = st_ff.tx[7];
						nxt_st.tx       = {st_ff.tx[6:0], 1'b0};
						nxt_st.icnt     = st_ff.icnt + 4'h1;
					end
				end
				I_MACK: begin
					if (i_rise && !st_ff.s2.sda) begin
						nxt_st.iwa      = st_ff.iwa + 1'b1;
						nxt_st.reg_rd   = 1'b1;
						nxt_st.reg_addr = st_ff.iwa + 1'b1;
						nxt_st.ist      = I_SEND;
						nxt_st.icnt     = '0;
					end else if (i_rise) begin
						nxt_st.ist = I_IDLE;
					end
				end
			endcase
		end

		// Write path with direct-command decode
		if (wr_req) begin
			if (wr_addr == slp_pkg::ADDR_RESTORE) begin
				nxt_st.restore = (wr_data == slp_pkg::DC_MAGIC);
			end else if (wr_addr == slp_pkg::ADDR_CALIB) begin
				nxt_st.calib = (wr_data == slp_pkg::DC_MAGIC);
			end else begin
				nxt_st.reg_wr    = 1'b1;
				nxt_st.reg_addr  = wr_addr;
				nxt_st.reg_wdata = wr_data;
			end
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Pin stages reset high, the idle level of select and the I2C lines, so no false START or STOP follows reset
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_ff           <= '0;
			st_ff.s1        <= '1;
			st_ff.s2        <= '1;
			st_ff.s3        <= '1;
			st_ff.sst       <= SP_CMD;
			st_ff.ist       <= I_IDLE;
			st_ff.miso_oe_n <= 1'b1;
			st_ff.sda_oe_n  <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign o_reg_wr           = st_ff.reg_wr;
	assign o_reg_rd           = st_ff.reg_rd;
	assign o_reg_addr         = st_ff.reg_addr;
	assign o_reg_wdata        = st_ff.reg_wdata;
	assign o_restore_defaults = st_ff.restore;
	assign o_calibrate        = st_ff.calib;
	assign bus.spi_miso_o     = st_ff.miso;
	assign bus.spi_miso_oe_n  = st_ff.miso_oe_n;
	assign bus.dev_sda_o      = 1'b0;  // Open drain: only ever pulls low
	assign bus.dev_sda_oe_n   = st_ff.sda_oe_n;
endmodule
`default_nettype wire

// *** rtl/slp_host.sv ***
// Bus master end: drives single-byte SPI or I2C register accesses
`timescale 1ns/1ps
`default_nettype none
module slp_host #(
	parameter int SPI_HALF = slp_pkg::SPI_HALF,
	parameter int I2C_QTR  = slp_pkg::I2C_QTR
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	// Command port
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [7:0]       o_rdata,
	// Serial pins
	slp_if.host              bus
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		H_IDLE = 4'h1, H_SPI = 4'h2, H_TOG = 4'h4, H_I2C = 4'h8
	} slp_host_fsm_t;
	typedef struct packed {
		logic [1:0]                 s1, s2;
		slp_host_fsm_t              hst;
		logic [7:0]                 tk;
		logic [1:0]                 ph;
		logic [5:0]                 idx;
		logic                       op_rd, use_i2c, nack_err;
		logic [1:0]                 asel;
		logic [slp_pkg::ADDR_W-1:0] addr;
		logic [7:0]                 wdata, rx, rdata;
		logic [15:0]                sh;
		logic                       cs_n, sclk, mosi, scl_oe_n, sda_oe_n;
	} slp_host_st_t;

	slp_host_st_t st_ff, nxt_st;

	// One I2C symbol: {kind, level released/driven, role}
	function automatic logic [4:0] slp_sym(input logic [5:0] i, input logic rd,
		input logic [7:0] dw, input logic [7:0] wa, input logic [7:0] wd);
		logic [7:0] b;
		logic [5:0] s;
		b       = wa;
		s       = slp_pkg::SL_WA;
		slp_sym = {slp_pkg::K_STOP, 1'b1, slp_pkg::R_DRV};
		if (i == '0 || (rd && i == slp_pkg::SL_RSTART)) begin
			slp_sym = {slp_pkg::K_START, 1'b1, slp_pkg::R_DRV};
		end else if (i == slp_pkg::SL_ACK1 || i == slp_pkg::SL_ACK2
			|| i == (rd ? slp_pkg::SL_RACK : slp_pkg::SL_WACK)) begin
			slp_sym = {slp_pkg::K_BIT, 1'b1, slp_pkg::R_ACK};
		end else if (rd && i == slp_pkg::SL_NACK) begin
			slp_sym = {slp_pkg::K_BIT, 1'b1, slp_pkg::R_NACK};
		end else if (rd ? i < slp_pkg::SL_NACK : i < slp_pkg::SL_WACK) begin
			if (i < slp_pkg::SL_WA) begin
				b = dw;
				s = slp_pkg::SL_DEV;
			end else if (i >= slp_pkg::SL_WDAT && !rd) begin
				b = wd;
				s = slp_pkg::SL_WDAT;
			end else if (i >= slp_pkg::SL_RDAT) begin
				b = 8'hFF;
				s = slp_pkg::SL_RDAT;
			end else if (i >= slp_pkg::SL_DEVR) begin
				b = dw | 8'h01;
				s = slp_pkg::SL_DEVR;
			end
			slp_sym = {slp_pkg::K_BIT, b[3'(s + slp_pkg::SL_SPAN - i)],
				(rd && i >= slp_pkg::SL_RDAT) ? slp_pkg::R_RX : slp_pkg::R_DRV};
		end
	endfunction

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic       tick;
		logic [4:0] sy;
		tick   = (st_ff.tk == '0);
		sy     = slp_sym(st_ff.idx, st_ff.op_rd,
			{1'b0, slp_pkg::I2C_DEV_PREFIX, st_ff.asel, 1'b0}, {2'h0, st_ff.addr},
			st_ff.wdata);
		nxt_st = st_ff;
		nxt_st.s1    = {bus.spi_miso, bus.sda};
		nxt_st.s2    = st_ff.s1;
		nxt_st.rdata = '0;
		if (st_ff.hst != H_IDLE) begin
			nxt_st.tk = !tick ? st_ff.tk - 8'h01 :
				st_ff.use_i2c ? 8'(I2C_QTR - 1) : 8'(SPI_HALF - 1);
		end
		// Register writes; a start is ignored while busy
		if (i_wr) begin
			unique case (i_addr)
				slp_pkg::HR_ADDR:  nxt_st.addr  = i_wdata[slp_pkg::ADDR_W-1:0];
				slp_pkg::HR_WDATA: nxt_st.wdata = i_wdata;
				slp_pkg::HR_CTRL: begin
					if (st_ff.hst == H_IDLE) begin
						nxt_st.use_i2c = i_wdata[slp_pkg::CTRL_I2C];
						nxt_st.asel = i_wdata[slp_pkg::CTRL_ASEL_HI:slp_pkg::CTRL_ASEL_LO];
						if (i_wdata[slp_pkg::CTRL_WR] || i_wdata[slp_pkg::CTRL_RD]) begin
							nxt_st.op_rd    = i_wdata[slp_pkg::CTRL_RD];
							nxt_st.idx      = '0;
							nxt_st.ph       = '0;
							nxt_st.nack_err = 1'b0;
							nxt_st.tk = i_wdata[slp_pkg::CTRL_I2C] ? 8'(I2C_QTR - 1)
								: 8'(SPI_HALF - 1);
							nxt_st.hst  = i_wdata[slp_pkg::CTRL_I2C] ? H_I2C : H_SPI;
							nxt_st.cs_n = i_wdata[slp_pkg::CTRL_I2C];
							nxt_st.sh   = {i_wdata[slp_pkg::CTRL_RD] ? slp_pkg::MODE_READ
								: slp_pkg::MODE_WRITE, st_ff.addr, st_ff.wdata};
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Register reads, data in the following cycle
		if (i_rd) begin
			unique case (i_addr)
				slp_pkg::HR_ADDR:   nxt_st.rdata = {2'h0, st_ff.addr};
				slp_pkg::HR_WDATA:  nxt_st.rdata = st_ff.wdata;
				slp_pkg::HR_CTRL:   nxt_st.rdata = {3'h0, st_ff.asel, st_ff.use_i2c, 2'h0};
				slp_pkg::HR_STATUS: nxt_st.rdata = {6'h00, st_ff.nack_err, st_ff.hst != H_IDLE};
				slp_pkg::HR_RDATA:  nxt_st.rdata = st_ff.rx;
				default:            nxt_st.rdata = '0;
			endcase
		end
		// Link sequencer
		unique case (st_ff.hst)
			H_IDLE: begin
			end
			H_SPI: begin
				// sixteen bits, then one half before select rises
				if (tick && st_ff.ph == 2'h0 && st_ff.idx == 6'(slp_pkg::SPI_BITS)) begin
					nxt_st.cs_n = 1'b1;
					nxt_st.hst  = st_ff.op_rd ? H_TOG : H_IDLE;
				end else if (tick && st_ff.ph == 2'h0) begin
					nxt_st.sclk = 1'b1;
					nxt_st.mosi = st_ff.sh[15];
					nxt_st.sh   = {st_ff.sh[14:0], 1'b0};
					nxt_st.ph   = 2'h1;
				end else if (tick) begin
					nxt_st.sclk = 1'b0;
					nxt_st.rx   = {st_ff.rx[6:0], st_ff.s2[1]};
					nxt_st.idx  = st_ff.idx + 6'h01;
					nxt_st.ph   = 2'h0;
				end
			end
			H_TOG: begin
				if (tick) begin
					nxt_st.cs_n = st_ff.ph != 2'h0;
					nxt_st.ph   = st_ff.ph + 2'h1;
					nxt_st.hst  = st_ff.ph != 2'h0 ? H_IDLE : H_TOG;
				end
			end
			H_I2C: begin
				if (tick) begin
					nxt_st.ph = st_ff.ph + 2'h1;
					unique case (st_ff.ph)
						2'h0: nxt_st.sda_oe_n = (sy[4:3] != slp_pkg::K_STOP) & sy[2];
						2'h1: nxt_st.scl_oe_n = 1'b1;
						2'h2: begin
							// START with clock high, STOP releases data
							if (sy[4:3] != slp_pkg::K_BIT) begin
								nxt_st.sda_oe_n = sy[4:3] == slp_pkg::K_STOP;
							end else if (sy[1:0] == slp_pkg::R_RX) begin
								nxt_st.rx = {st_ff.rx[6:0], st_ff.s2[0]};
							end else if (sy[1:0] == slp_pkg::R_ACK && st_ff.s2[0]) begin
								nxt_st.nack_err = 1'b1;
							end
						end
						default: begin
							nxt_st.scl_oe_n = sy[4:3] == slp_pkg::K_STOP;
							nxt_st.idx      = st_ff.idx + 6'h01;
							if (sy[4:3] == slp_pkg::K_STOP) begin
								nxt_st.hst = H_IDLE;
							end
						end
					endcase
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_ff          <= '0;
			st_ff.hst      <= H_IDLE;
			st_ff.cs_n     <= 1'b1;
			st_ff.scl_oe_n <= 1'b1;
			st_ff.sda_oe_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign o_rdata           = st_ff.rdata;
	assign bus.spi_cs_n      = st_ff.cs_n;
	assign bus.spi_sclk      = st_ff.sclk;
	assign bus.spi_mosi      = st_ff.mosi;
	assign bus.host_scl_o    = 1'b0;
	assign bus.host_scl_oe_n = st_ff.scl_oe_n;
	assign bus.host_sda_o    = 1'b0;
	assign bus.host_sda_oe_n = st_ff.sda_oe_n;
endmodule
`default_nettype wire

// *** verif/slp_checker.sv ***
// Pin-level protocol checker for the serial port
`timescale 1ns/1ps
`default_nettype none
module slp_checker (
	input wire logic i_clk, i_reset, spi_cs_n, spi_sclk, spi_miso,
	input wire logic spi_miso_oe_n, scl, sda, dev_sda_oe_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Slack of five cycles covers the select synchroniser
	a_miso_released: assert property (spi_cs_n [*5] |-> spi_miso_oe_n)
		else $error("return line driven while deselected");
	a_sclk_idle: assert property (spi_cs_n && $past(spi_cs_n) |-> !spi_sclk)
		else $error("serial clock moves while deselected");
	a_cs_lead: assert property ($fell(spi_cs_n) |-> !spi_sclk [*6])
		else $error("clock too soon after select");
	a_sclk_high: assert property ($rose(spi_sclk) |-> spi_sclk [*6])
		else $error("serial clock high phase short");
	a_miso_on_rise: assert property (!spi_miso_oe_n && $past(!spi_miso_oe_n)
		&& $changed(spi_miso) |-> spi_sclk)
		else $error("read data changed off the rising phase");
	a_scl_low: assert property ($fell(scl) |-> !scl [*8])
		else $error("i2c clock low phase short");
	a_sda_release: assert property ($fell(dev_sda_oe_n) |-> ##[1:400] dev_sda_oe_n)
		else $error("device holds data line too long");
	a_links_apart: assert property (!spi_cs_n |-> scl && sda)
		else $error("i2c lines busy during spi frame");
	c_spi: cover property ($fell(spi_cs_n));
	c_ack: cover property ($fell(dev_sda_oe_n));
	c_miso: cover property ($rose(spi_miso_oe_n));
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Bench joining host and device ends of the serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       i_clk = 0, i_reset = 1, sel = 0, a_hi = 0, a_lo = 0, i_wr = 0, i_rd = 0;
	logic [7:0] i_addr = 0, i_wdata = 0, rdata, rd_q = 0, reg_wdata, mem [64];
	logic [5:0] reg_addr;
	logic       reg_wr, reg_rd, restore, calib;
	int         n_fail = 0, num_checks = 0, cyc = 0, n_rst = 0, n_cal = 0;
	slp_if bus ();
	slp_device slp_device_i (.i_clk, .i_reset, .i_interface_select(sel),
		.i_addr_sel_high(a_hi), .i_addr_sel_low(a_lo), .o_reg_wr(reg_wr),
		.o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
		.i_reg_rdata(rd_q), .o_restore_defaults(restore), .o_calibrate(calib), .bus(bus));
	slp_host slp_host_i (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata(rdata), .bus(bus));
	slp_checker slp_checker_i (.i_clk, .i_reset, .spi_cs_n(bus.spi_cs_n),
		.spi_sclk(bus.spi_sclk), .spi_miso(bus.spi_miso), .spi_miso_oe_n(bus.spi_miso_oe_n),
		.scl(bus.scl), .sda(bus.sda), .dev_sda_oe_n(bus.dev_sda_oe_n));
	always #20 i_clk = ~i_clk;
	// Register file behind the device, read data one cycle late
	always @(posedge i_clk) begin
		if (reg_wr) mem[reg_addr] <= reg_wdata;
		if (reg_rd) rd_q <= mem[reg_addr];
		if (restore) n_rst <= n_rst + 1;
		if (calib) n_cal <= n_cal + 1;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			conclude();
		end
	end
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = rdata;
	endtask
	// One link transfer, then poll busy; hangs are left to the cycle limit
	task automatic op(logic [7:0] ctl, logic [5:0] a, logic [7:0] d, output logic [7:0] s);
		wr(slp_pkg::HR_ADDR, {2'h0, a});
		wr(slp_pkg::HR_WDATA, d);
		wr(slp_pkg::HR_CTRL, ctl);
		s = 8'h01;
		while (s[0] !== 1'b0) rd(slp_pkg::HR_STATUS, s);
		rd(slp_pkg::HR_RDATA, d);
		s = d;
	endtask
	task automatic t_spi;
		logic [7:0] r;
		op(8'h01, 6'h32, 8'hC3, r);
		chk("spi write", 8'hC3, mem[6'h32]);
		op(8'h02, 6'h07, 8'h00, r);
		chk("spi read", 8'h87, r);
		op(8'h01, 6'h3D, 8'h55, r);
		chk("calib ignored", 8'h00, n_cal[7:0]);
		op(8'h01, 6'h3C, 8'h96, r);
		chk("restore", 8'h01, n_rst[7:0]);
		chk("restore no write", 8'hBC, mem[6'h3C]);
		op(8'h01, 6'h3D, 8'h96, r);
		chk("calib", 8'h01, n_cal[7:0]);
		op(8'h15, 6'h14, 8'h44, r);
		chk("i2c ignored", 8'h94, mem[6'h14]);
		$display("spi test done");
	endtask
	task automatic t_i2c;
		logic [7:0] r;
		sel <= 1'b1;
		a_hi <= 1'b1;
		repeat (4) @(posedge i_clk);
		op(8'h15, 6'h11, 8'h3A, r);
		chk("i2c write", 8'h3A, mem[6'h11]);
		op(8'h16, 6'h11, 8'h00, r);
		chk("i2c read back", 8'h3A, r);
		op(8'h16, 6'h20, 8'h00, r);
		chk("i2c read", 8'hA0, r);
		op(8'h15, 6'h3C, 8'h96, r);
		chk("i2c restore", 8'h02, n_rst[7:0]);
		op(8'h01, 6'h13, 8'h44, r);
		chk("spi ignored", 8'h93, mem[6'h13]);
		op(8'h0D, 6'h12, 8'h77, r);
		rd(slp_pkg::HR_STATUS, r);
		chk("wrong address nack", 8'h02, r & 8'h02);
		chk("wrong address", 8'h92, mem[6'h12]);
		// Swap the strap pins so the low address pin is exercised too
		a_hi <= 1'b0;
		a_lo <= 1'b1;
		repeat (4) @(posedge i_clk);
		op(8'h0D, 6'h12, 8'h77, r);
		chk("low pin address", 8'h77, mem[6'h12]);
		$display("i2c test done");
	endtask
	task automatic conclude;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 64; i++) mem[i] = {2'h2, 6'(i)};
		repeat (5) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (4) @(posedge i_clk);
		t_spi();
		t_i2c();
		conclude();
	end
endmodule
`default_nettype wire
